// ---- inc/asfe_params.svh ----
// Constants for the audio serial format engine: map, reset values, lengths
// How it works
// RULE1: RJ sender places each LSB for capture on the last edge before frame change.
// RULE2: RJ transmitter launches the LSB on the falling edge just before frame change.
// RULE3: RJ frame clock high carries left, low carries right, unless inverted.
// RULE4: I2S receiver samples the MSB on the second rising edge after frame change.
// RULE5: I2S transmitter launches the MSB on the first falling edge after frame change.
// RULE6: I2S frame clock low carries left, high carries right, unless inverted.
// RULE7: DSP A receiver samples channel 1 left MSB on second edge after sync rise.
// RULE8: DSP primary receiver takes four pairs on one line; secondary only one pair.
// RULE9: DSP A transmitter launches left MSB on first falling edge; right follows.
// RULE10: DSP B receiver samples channel 1 left MSB on first edge after sync rise.
// RULE11: DSP B transmitter launches left MSB with the sync rise; right follows.
// RULE12: By default data and frame are sampled rising, data launched falling.
// RULE13: Bit-clock polarity bit 5 swaps the sample and launch edges.
// RULE14: Bit 4 inverts frame clock outside DSP; in DSP selects mode A or B.
// RULE15: Format field 1:0 is 11 DSP, 10 I2S, 01 LJ, 00 RJ; resets 10.
// RULE16: Word length field 3:2 is 32, 24, 20, 16 bits; resets to 24.
// RULE17: RJ with word length code 11 runs at 24 bits.
// RULE18: Words map to 24 bits: short ones zero padded, 32-bit drop 8 LSBs.
// RULE19: In 24-bit I2S sender may use up to 24 bits if halves last 24.
// RULE20: Exactly 32 bit clocks in a frame period forces 16-bit words; the code does so outside DSP only.
// RULE21: Software should not change the format while audio runs.
// RULE22: Secondary control bit 6 enables the secondary port; resets to 0.
// RULE23: LJ samples MSB first rising edge after change; launches it with change.
// RULE24: Non-DSP frame holds two words; each frame level lasts one word.
// RULE25: DSP frame holds eight words; sync rise marks the first word.
// RULE26: Disabled secondary port takes no samples, sends nothing, framing stays idle.
`ifndef ASFE_PARAMS_SVH
`define ASFE_PARAMS_SVH
`define ASFE_PRX_ADDR 7'h0C
`define ASFE_PTX_ADDR 7'h0D
`define ASFE_SEC_ADDR 7'h0E
`define ASFE_PRI_RST 7'h4A
`define ASFE_SEC_RST 7'h0A
`define ASFE_INT_W 24
`define ASFE_WL_16 6'h10
`define ASFE_WL_20 6'h14
`define ASFE_WL_24 6'h18
`define ASFE_WL_32 6'h20
`define ASFE_AUTO_LAST 8'h1F
`define ASFE_CNT_MAX 8'hFF
`endif

// ---- inc/asfe_pkg.sv ----
// Types shared by the audio serial format engine
`include "asfe_params.svh"
package asfe_pkg;
  typedef enum logic [1:0] {FMT_RJ, FMT_LJ, FMT_I2S, FMT_DSP} asfe_fmt_t;
  typedef struct packed {
    logic       en;   // Port enable
    logic       bcp;  // Bit-clock polarity
    logic       lrp;  // Frame polarity, or DSP mode B
    logic [1:0] wl;   // Word-length code
    asfe_fmt_t  fmt;  // Framing select
  } asfe_ctrl_t;
  typedef logic [`ASFE_INT_W-1:0] asfe_word_t;
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [8:0] wdata;
  } asfe_reg_req_t;
  typedef struct packed {
    logic                  valid;
    logic                  right;
    logic [1:0]            pair;
    logic [3:0][`ASFE_INT_W-1:0] word;
  } asfe_rx_t;
endpackage

// ---- core/asfe_top.sv ----
// Audio serial port framing: per-port engine and register front end
`timescale 1ns/1ps
`include "asfe_params.svh"

module asfe_port #(
  parameter int NLINE = 4,  // Serial data lines
  parameter int NPAIR = 4   // Stereo pairs in DSP format
) (
  input  logic                 core_clk,   // Core clock
  input  logic                 rst_b,      // Async reset
  input  asfe_pkg::asfe_ctrl_t ctrl,       // Port control
  input  logic                 bclk_pin,   // Bit clock
  input  logic                 lrclk_pin,  // Frame clock
  input  logic [NLINE-1:0]     din_pin,    // Serial data in
  input  asfe_pkg::asfe_word_t tx_left,    // Left word to send
  input  asfe_pkg::asfe_word_t tx_right,   // Right word to send
  output asfe_pkg::asfe_rx_t   rx,         // Received words
  output logic                 dout,       // Serial data out
  output logic                 tx_load     // Words taken
);
  import asfe_pkg::*;

  function automatic logic [7:0] start_of(input asfe_ctrl_t c);
    return (c.fmt == FMT_I2S || (c.fmt == FMT_DSP && !c.lrp)) ? 8'h01 : 8'h00;
  endfunction

  function automatic logic [5:0] wl_of(input asfe_ctrl_t c, input logic a16);
    logic [5:0] w;
    unique case (c.wl)
      2'b00: w = `ASFE_WL_16;
      2'b01: w = `ASFE_WL_20;
      2'b10: w = `ASFE_WL_24;
      2'b11: w = (c.fmt == FMT_RJ) ? `ASFE_WL_24 : `ASFE_WL_32; // RULE16 RULE17
    endcase
    if (a16 && c.fmt != FMT_DSP)
      w = `ASFE_WL_16; // RULE20
    return w;
  endfunction

  // Left-align the word, then keep the top 24 bits
  function automatic asfe_word_t to24(input logic [31:0] v, input logic [5:0] w);
    logic [31:0] t;
    t = v << (6'h20 - w);
    return t[31:8]; // RULE18
  endfunction

  function automatic logic [31:0] to32(input asfe_word_t v);
    return {v, 8'h00};
  endfunction

  // DSP pair: the right word starts just after the last left bit, not at bit 32
  function automatic logic [63:0] pack2(input asfe_word_t l, input asfe_word_t r,
                                        input logic [5:0] w);
    logic [63:0] keep;
    keep = ~(64'hFFFF_FFFF_FFFF_FFFF >> w);
    return ({to32(l), 32'h0} & keep) | ({to32(r), 32'h0} >> w); // RULE9 RULE11
  endfunction

  function automatic logic [7:0] inc8(input logic [7:0] x);
    return (x == `ASFE_CNT_MAX) ? x : x + 8'h01;
  endfunction

  logic [2:0]       bclk_q;
  logic [1:0]       lr_q;
  logic [3:0]       din_q1;
  logic [3:0]       din_q2;
  logic             samp_e;
  logic             launch_e;
  logic             dsp;
  logic             rj;
  logic             lr;
  logic             auto16;
  logic [5:0]       wl;
  logic             lr_rx;
  logic             ractive;
  logic [7:0]       rcnt;
  logic [7:0]       pcnt;
  logic [7:0]       rcur;
  logic [5:0]       bitw;
  logic [5:0]       ridx;
  logic [2:0]       slot;
  logic [2:0]       rslot;
  logic [3:0][31:0] rsh;
  logic [3:0][31:0] next_rsh;
  logic             rx_start;
  logic             rgo;
  logic             rdone;
  logic             lr_tx;
  logic             tact;
  logic             tx_start;
  logic             tgo;
  logic [7:0]       tcnt;
  logic [7:0]       tcur;
  logic [7:0]       half;
  logic [6:0]       tleft;
  logic [6:0]       tspan;
  logic [63:0]      tsh;
  logic [63:0]      tword;

  // Pins come from the host's clock; the link clock is only sampled here
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bclk_q <= 3'h0;
      lr_q   <= 2'h0;
      din_q1 <= 4'h0;
      din_q2 <= 4'h0;
    end
    else
    begin
      bclk_q <= {bclk_q[1:0], bclk_pin};
      lr_q   <= {lr_q[0], lrclk_pin};
      din_q1 <= 4'(din_pin);
      din_q2 <= din_q1;
    end
  end

  assign dsp      = ctrl.fmt == FMT_DSP; // RULE15
  assign rj       = ctrl.fmt == FMT_RJ;
  assign samp_e   = ctrl.en && bclk_q[2:1] == (ctrl.bcp ? 2'b10 : 2'b01); // RULE12 RULE13
  assign launch_e = ctrl.en && bclk_q[2:1] == (ctrl.bcp ? 2'b01 : 2'b10); // RULE12 RULE13
  assign lr       = lr_q[1] ^ (ctrl.lrp && !dsp); // RULE14
  assign wl       = wl_of(ctrl, auto16);

  // Frame period in sample edges, measured rise to rise
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pcnt   <= 8'h00;
      auto16 <= 1'b0;
    end
    else if (!ctrl.en)
    begin
      pcnt   <= 8'h00;
      auto16 <= 1'b0;
    end
    else if (samp_e)
    begin
      pcnt <= (lr && !lr_rx) ? 8'h00 : inc8(pcnt);
      if (lr && !lr_rx)
        auto16 <= pcnt == `ASFE_AUTO_LAST; // RULE20
    end
  end

  // DSP counts from the sync rise only; other formats from either level change
  assign rx_start = dsp ? (lr && !lr_rx) : (lr != lr_rx); // RULE25
  assign rcur     = rx_start ? 8'h00 : inc8(rcnt);
  assign rgo      = !rj && rcur == start_of(ctrl); // RULE4 RULE7 RULE10 RULE23
  assign ridx     = rgo ? 6'h00 : bitw;
  assign rslot    = rgo ? 3'h0 : slot;
  assign rdone    = (rgo || ractive) && ridx == wl - 6'h01;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      next_rsh[i] = {rsh[i][30:0], din_q2[i]};
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Saturated count: no word may start before a frame edge has been seen
      lr_rx   <= 1'b0;
      rcnt    <= `ASFE_CNT_MAX;
      ractive <= 1'b0;
      bitw    <= 6'h00;
      slot    <= 3'h0;
      rsh     <= '0;
    end
    else if (!ctrl.en)
    begin
      lr_rx   <= 1'b0; // RULE22 RULE26
      rcnt    <= `ASFE_CNT_MAX;
      ractive <= 1'b0;
      bitw    <= 6'h00;
      slot    <= 3'h0;
    end
    else if (samp_e)
    begin
      lr_rx <= lr;
      rcnt  <= rcur;
      rsh   <= next_rsh;
      if (rdone)
      begin
        bitw    <= 6'h00;
        slot    <= rslot + 3'h1;
        ractive <= dsp && rslot != 3'(2 * NPAIR - 1); // RULE8
      end
      else if (rgo || ractive)
      begin
        bitw    <= ridx + 6'h01;
        slot    <= rslot;
        ractive <= 1'b1;
      end
    end
  end

  // RJ words end on the edge before the level change, so they close on it
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rx <= '0;
    else
    begin
      rx.valid <= 1'b0;
      if (samp_e && rj && lr != lr_rx)
      begin
        rx.valid <= 1'b1;
        rx.right <= !lr_rx; // RULE1 RULE3
        rx.pair  <= 2'h0;
        for (int i = 0; i < 4; i++)
          rx.word[i] <= to24(rsh[i], wl);
      end
      else if (samp_e && rdone)
      begin
        rx.valid <= 1'b1;
        rx.right <= dsp ? rslot[0] : (ctrl.fmt == FMT_I2S) ? lr : !lr; // RULE6
        rx.pair  <= dsp ? rslot[2:1] : 2'h0; // RULE8
        for (int i = 0; i < 4; i++)
          rx.word[i] <= (dsp && i != 0) ? '0 : to24(next_rsh[i], wl);
      end
    end
  end

  // RJ launch point needs the previous half length; the first half sends nothing
  assign tx_start = dsp ? (lr && !lr_tx) : (lr != lr_tx);
  assign tcur     = tx_start ? 8'h00 : inc8(tcnt);
  assign tgo      = rj ? (tcur == half - 8'(wl)) : (tcur == start_of(ctrl)); // RULE2 RULE5
  assign tspan    = dsp ? {wl, 1'b0} : {1'b0, wl}; // RULE9 RULE11
  assign tword    = dsp ? pack2(tx_left, tx_right, wl)
                  : {to32(((ctrl.fmt == FMT_I2S) ? lr : !lr) ? tx_right : tx_left), 32'h0};

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lr_tx   <= 1'b0;
      tcnt    <= `ASFE_CNT_MAX;
      half    <= 8'h00;
      tact    <= 1'b0;
      tleft   <= 7'h00;
      tsh     <= '0;
      dout    <= 1'b0;
      tx_load <= 1'b0;
    end
    else if (!ctrl.en)
    begin
      lr_tx   <= 1'b0; // RULE26
      tcnt    <= `ASFE_CNT_MAX;
      half    <= 8'h00;
      tact    <= 1'b0;
      dout    <= 1'b0;
      tx_load <= 1'b0;
    end
    else
    begin
      tx_load <= launch_e && tgo;
      if (launch_e)
      begin
        lr_tx <= lr;
        tcnt  <= tcur;
        if (lr != lr_tx)
          half <= inc8(tcnt);
        if (tgo)
        begin
          dout  <= tword[63]; // RULE23
          tsh   <= tword << 1;
          tleft <= tspan - 7'h01;
          tact  <= tspan != 7'h01;
        end
        else if (tact)
        begin
          dout  <= tsh[63];
          tsh   <= tsh << 1;
          tleft <= tleft - 7'h01;
          tact  <= tleft != 7'h01;
        end
        else
          dout <= 1'b0;
      end
    end
  end

  default clocking asfe_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence rx_word;
    samp_e && rdone;
  endsequence

  sequence dsp_b_rise;
    launch_e && dsp && ctrl.lrp && lr && !lr_tx;
  endsequence

  rx_word_pulse_a: assert property (rx_word |=> rx.valid ##1 !rx.valid) // RULE12
    else $error("received word not flagged for exactly one cycle");
  rx_edge_only_a: assert property (rx.valid |-> $past(samp_e)) // RULE13
    else $error("received word not tied to a sample edge");
  tx_edge_only_a: assert property ($past(ctrl.en) && $changed(dout) |-> $past(launch_e)) // RULE12
    else $error("serial output changed off the launch edge");
  dsp_b_launch_a: assert property (dsp_b_rise |=> tx_load && dout == tword[63]) // RULE11
    else $error("mode B word not launched with the sync rise");
  late_launch_a: assert property (tx_load && !rj && start_of(ctrl) == 8'h01 |-> tcnt == 8'h01) // RULE5
    else $error("delayed format launched on the wrong edge");
  rx_msb_edge_a: assert property ($rose(ractive) && !rj |-> rcnt == start_of(ctrl)) // RULE4
    else $error("first data bit captured on the wrong edge");
  rj_len_a: assert property (rj && ctrl.wl == 2'b11 && !auto16 |-> wl == `ASFE_WL_24) // RULE17
    else $error("right justified long word not forced to 24 bits");
  auto_len_a: assert property (auto16 && !dsp |-> wl == `ASFE_WL_16) // RULE20
    else $error("32 clock frame did not select 16-bit words");
  pad_low_a: assert property (rx.valid && $past(wl) == `ASFE_WL_16 |-> rx.word[0][7:0] == 8'h00) // RULE18
    else $error("short word not zero padded");
  off_idle_a: assert property (!ctrl.en |=> !rx.valid && !dout && !tx_load && !ractive) // RULE26
    else $error("disabled port still active");

endmodule // asfe_port

module asfe_top (
  input  logic                    core_clk,           // 25 MHz core clock
  input  logic                    rst_b,              // Async reset
  input  asfe_pkg::asfe_reg_req_t reg_req,            // Register access
  output logic [8:0]              reg_rdata,          // Register read data
  input  logic                    pri_rx_bclk,        // Primary rx bit clock
  input  logic                    pri_rx_lrclk,       // Primary rx frame clock
  input  logic [3:0]              serial_data_inputs, // Primary rx data
  output asfe_pkg::asfe_rx_t      pri_rx,             // Primary rx words
  input  logic                    pri_tx_bclk,        // Primary tx bit clock
  input  logic                    pri_tx_lrclk,       // Primary tx frame clock
  input  asfe_pkg::asfe_word_t    pri_tx_left,        // Primary tx left word
  input  asfe_pkg::asfe_word_t    pri_tx_right,       // Primary tx right word
  output logic                    pri_tx_dout,        // Primary tx data
  output logic                    pri_tx_load,        // Primary words taken
  input  logic                    sec_bclk,           // Secondary bit clock
  input  logic                    sec_lrclk,          // Secondary frame clock
  input  logic                    sec_din,            // Secondary rx data
  input  asfe_pkg::asfe_word_t    sec_tx_left,        // Secondary tx left
  input  asfe_pkg::asfe_word_t    sec_tx_right,       // Secondary tx right
  output asfe_pkg::asfe_rx_t      sec_rx,             // Secondary rx words
  output logic                    sec_dout,           // Secondary tx data
  output logic                    sec_load            // Secondary words taken
);
  import asfe_pkg::*;

  asfe_ctrl_t primary_rx_format_ctrl;
  asfe_ctrl_t primary_tx_format_ctrl;
  asfe_ctrl_t secondary_format_ctrl;

  // Primary ports have no enable bit, so it is held set internally
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      primary_rx_format_ctrl <= asfe_ctrl_t'(`ASFE_PRI_RST); // RULE15 RULE16
      primary_tx_format_ctrl <= asfe_ctrl_t'(`ASFE_PRI_RST);
      secondary_format_ctrl  <= asfe_ctrl_t'(`ASFE_SEC_RST); // RULE22
    end
    else if (reg_req.wr)
    begin
      case (reg_req.addr)
        `ASFE_PRX_ADDR: primary_rx_format_ctrl <= asfe_ctrl_t'({1'b1, reg_req.wdata[5:0]});
        `ASFE_PTX_ADDR: primary_tx_format_ctrl <= asfe_ctrl_t'({1'b1, reg_req.wdata[5:0]});
        `ASFE_SEC_ADDR: secondary_format_ctrl  <= asfe_ctrl_t'(reg_req.wdata[6:0]); // RULE22
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 9'h000;
    else
    begin
      case (reg_req.addr)
        `ASFE_PRX_ADDR: reg_rdata <= {3'h0, primary_rx_format_ctrl[5:0]};
        `ASFE_PTX_ADDR: reg_rdata <= {3'h0, primary_tx_format_ctrl[5:0]};
        `ASFE_SEC_ADDR: reg_rdata <= {2'h0, secondary_format_ctrl};
        default:        reg_rdata <= 9'h000;
      endcase
    end
  end

  asfe_port #(.NLINE(4), .NPAIR(4)) u_pri_rx (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .ctrl      (primary_rx_format_ctrl),
    .bclk_pin  (pri_rx_bclk),
    .lrclk_pin (pri_rx_lrclk),
    .din_pin   (serial_data_inputs),
    .tx_left   ('0),
    .tx_right  ('0),
    .rx        (pri_rx),
    .dout      (),
    .tx_load   ()
  );

  asfe_port #(.NLINE(1), .NPAIR(1)) u_pri_tx (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .ctrl      (primary_tx_format_ctrl),
    .bclk_pin  (pri_tx_bclk),
    .lrclk_pin (pri_tx_lrclk),
    .din_pin   (1'b0),
    .tx_left   (pri_tx_left),
    .tx_right  (pri_tx_right),
    .rx        (),
    .dout      (pri_tx_dout),
    .tx_load   (pri_tx_load)
  );

  asfe_port #(.NLINE(1), .NPAIR(1)) u_sec (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .ctrl      (secondary_format_ctrl),
    .bclk_pin  (sec_bclk),
    .lrclk_pin (sec_lrclk),
    .din_pin   (sec_din),
    .tx_left   (sec_tx_left),
    .tx_right  (sec_tx_right),
    .rx        (sec_rx),
    .dout      (sec_dout),
    .tx_load   (sec_load)
  );

endmodule // asfe_top

// ---- testbench/asfe_host_model.sv ----
// Host serial port model: bit and frame clocks, data to device, capture of device data
`timescale 1ns/1ps

module asfe_host_model #(
  parameter int NP = 4  // Stereo pairs sent in DSP format
) (
  output logic      bclk,    // Bit clock to device
  output logic      lrclk,   // Frame clock to device
  output logic      sd,      // Data to device
  input  wire logic dev_sd,  // Data from device
  input  wire logic bcp      // Bit-clock polarity in use
);
  logic        clk_l = 1'b1;
  logic        dsp   = 1'b0;
  int          seed  = 32'hAA39;
  logic [50:0] exp_q[$];
  logic [31:0] cw[2];

  // Logical clock idles high; polarity only flips which physical edge launches
  assign bclk = clk_l ^ bcp;

  initial
  begin
    lrclk = 1'b0;
    sd    = 1'b0;
  end

  function automatic logic [23:0] to_path(input logic [31:0] x, input int w);
    logic [31:0] y;
    y = x & 32'((33'h1 << w) - 1);
    return (w >= 24) ? 24'(y >> (w - 24)) : 24'(y << (24 - w));
  endfunction

  // One extra slot closes each run so a right-justified word is framed off
  task automatic run(input logic [1:0] fmt, input logic lrp, input int w, nn, nh, skip);
    int          n;
    int          off;
    int          nw;
    int          j;
    int          b;
    int          ci;
    logic        lv0;
    logic        in_w;
    logic [31:0] r[8];
    #7;
    dsp = (fmt == 2'h3);
    lv0 = (fmt != 2'h2) ^ lrp;
    n   = (nn > 0) ? nn : dsp ? 8 * w + 2 : w + 3;
    nw  = dsp ? 2 * NP : 1;
    off = int'(fmt == 2'h2);
    if (fmt == 2'h0) off = n - w;
    if (dsp) off = int'(!lrp);
    lrclk = dsp ? 1'b0 : !lv0;
    // One idle cell first, so the device sees the level that the first word leaves
    clk_l = 1'b0;
    #160;
    clk_l = 1'b1;
    #160;
    for (int h = 0; h <= nh; h++)
    begin
      foreach (r[i]) r[i] = $random(seed);
      for (int k = 0; k < ((h == nh) ? 1 : n); k++)
      begin
        in_w = (h < nh) && (k >= off) && (k - off < nw * w);
        j = in_w ? (k - off) / w : 0;
        b = in_w ? w - 1 - (k - off) % w : 0;
        ci = dsp ? j : h % 2;
        clk_l = 1'b0;
        if (dsp) lrclk = (k == 0) && (h < nh);
        else if (k == 0) lrclk = lv0 ^ h[0];
        // Idle data toggles at random so a stale bit never passes for a match
        sd = in_w ? r[j][b] : 1'($random(seed));
        #160;
        clk_l = 1'b1;
        if (in_w && b == 0 && h >= skip)
          exp_q.push_back({dsp ? j[0] : h[0], dsp ? j[2:1] : 2'h0, to_path(r[j], w),
                           (dsp || NP == 1) ? 24'h0 : to_path(~r[j], w)});
        // Sync latency is near half a bit, so device data is taken at cell end
        #160;
        if (in_w && j < 2) cw[ci] = {cw[ci][30:0], dev_sd};
      end
    end
  endtask
endmodule // asfe_host_model

// ---- testbench/test_asfe_top.sv ----
// Self-checking bench: register port and framing of the three audio ports
`timescale 1ns/1ps

module test_asfe_top;
  import asfe_pkg::*;

  logic          core_clk = 1'b0;
  logic          rst_b    = 1'b0;
  asfe_reg_req_t reg_req  = '0;
  logic [8:0]    reg_rdata;
  logic          p_bclk, p_lrclk, p_sd, s_bclk, s_lrclk, s_sd;
  logic          pri_tx_dout, pri_tx_load, sec_dout, sec_load;
  logic          bcp = 1'b0;
  asfe_rx_t      pri_rx, sec_rx;
  asfe_word_t    ptl = '0, ptr = '0, stl = '0, str = '0;
  logic [50:0]   pg, se;
  int            n_mismatch = 0, cmp_count = 0, seed = 32'hAA39, s_valid = 0, s_dhi = 0;
  int            p_load = 0, s_load = 0;
  logic [8:0]    cfg[8] = '{9'h00A, 9'h011, 9'h02C, 9'h014, 9'h02E, 9'h003, 9'h037, 9'h039};
  int            wd[8]  = '{24, 16, 24, 20, 32, 16, 20, 24};

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  asfe_top DUT (
    .core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .pri_rx_bclk(p_bclk), .pri_rx_lrclk(p_lrclk),
    .serial_data_inputs({~p_sd, p_sd, p_sd, p_sd}), .pri_rx(pri_rx),
    .pri_tx_bclk(p_bclk), .pri_tx_lrclk(p_lrclk), .pri_tx_left(ptl), .pri_tx_right(ptr),
    .pri_tx_dout(pri_tx_dout), .pri_tx_load(pri_tx_load),
    .sec_bclk(s_bclk), .sec_lrclk(s_lrclk), .sec_din(s_sd), .sec_tx_left(stl),
    .sec_tx_right(str), .sec_rx(sec_rx), .sec_dout(sec_dout), .sec_load(sec_load));

  asfe_host_model #(.NP(4)) ph (.bclk(p_bclk), .lrclk(p_lrclk), .sd(p_sd),
    .dev_sd(pri_tx_dout), .bcp(bcp));
  asfe_host_model #(.NP(1)) sh (.bclk(s_bclk), .lrclk(s_lrclk), .sd(s_sd),
    .dev_sd(sec_dout), .bcp(bcp));

  task automatic end_sim;
    $display("Counts: compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [50:0] got, input logic [50:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(negedge core_clk) reg_req = '{1'b1, a, d};
    @(negedge core_clk) reg_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [8:0] e);
    @(negedge core_clk) reg_req = '{1'b0, a, 9'h000};
    @(negedge core_clk) chk(51'(reg_rdata), 51'(e));
  endtask

  function automatic logic [50:0] txe(input asfe_word_t x, input int w);
    return (w >= 24) ? 51'({x, 8'h00} >> (32 - w)) : 51'(x >> (24 - w));
  endfunction

  // Formats change only while both hosts hold their clocks still
  task automatic scen(input logic [8:0] c, input int w, input int nn, input int skip);
    logic [31:0] m;
    m = 32'((33'h1 << w) - 1);
    wr(7'h0C, c);
    wr(7'h0D, c);
    wr(7'h0E, c | 9'h040);
    bcp = c[5];
    ptl = 24'($random(seed));
    ptr = 24'($random(seed));
    stl = 24'($random(seed));
    str = 24'($random(seed));
    p_load = 0;
    s_load = 0;
    fork
      ph.run(c[1:0], c[4], w, nn, 4 + 4 * (nn > 0), skip);
      sh.run(c[1:0], c[4], w, nn, 4 + 4 * (nn > 0), skip);
    join
    repeat (20) @(negedge core_clk);
    chk(51'(ph.exp_q.size()), 51'h0);
    chk(51'(sh.exp_q.size()), 51'h0);
    chk(51'(ph.cw[0] & m), txe(ptl, w));
    chk(51'(ph.cw[1] & m), txe(ptr, w));
    chk(51'(sh.cw[0] & m), txe(stl, w));
    chk(51'(sh.cw[1] & m), txe(str, w));
    chk(51'(p_load >= 3), 51'h1);
    chk(51'(s_load >= 3), 51'h1);
    $display("Test done: config %h width %0d", c, w);
  endtask

  // Valids with no queued word (frames before lock-in) are not judged
  always @(negedge core_clk)
  begin
    if (sec_rx.valid === 1'b1) s_valid++;
    if (sec_dout === 1'b1) s_dhi++;
    if (pri_tx_load === 1'b1) p_load++;
    if (sec_load === 1'b1) s_load++;
    if (pri_rx.valid === 1'b1 && ph.exp_q.size() > 0)
    begin
      pg = {pri_rx.right, ph.dsp ? pri_rx.pair : 2'h0, pri_rx.word[0], pri_rx.word[3]};
      chk(pg, ph.exp_q.pop_front());
    end
    if (sec_rx.valid === 1'b1 && sh.exp_q.size() > 0)
    begin
      se = {sec_rx.right, sh.dsp ? sec_rx.pair : 2'h0, sec_rx.word[0], 24'h000000};
      chk(se, sh.exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk) rst_b = 1'b1;
    rd(7'h0C, 9'h00A);
    rd(7'h0D, 9'h00A);
    rd(7'h0E, 9'h00A);
    wr(7'h0F, 9'h1FF);
    rd(7'h0F, 9'h000);
    wr(7'h0C, 9'h1FF);
    rd(7'h0C, 9'h03F);
    wr(7'h0E, 9'h1FF);
    rd(7'h0E, 9'h07F);
    wr(7'h0E, 9'h00A);
    sh.run(2'h2, 1'b0, 24, 0, 4, 99);
    chk(51'(s_valid), 51'h0);
    chk(51'(s_dhi), 51'h0);
    $display("Test done: disabled secondary port");
    for (int i = 0; i < 8; i++) scen(cfg[i], wd[i], 0, 0);
    scen(9'h009, 16, 16, 5);
    end_sim;
  end

  initial
  begin
    #2000000;
    n_mismatch++;
    end_sim;
  end
endmodule // test_asfe_top
